// ===== shared/ppi_pkg.sv
// Shared constants and carriers for the bus pin interface
package ppi_pkg;
   localparam int unsigned AD_W = 32;
   localparam int unsigned CBE_W = 4;
   localparam logic [3:0] CMD_IO_RD = 4'h2;
   localparam logic [3:0] CMD_IO_WR = 4'h3;
   localparam logic [3:0] CMD_MEM_RD = 4'h6;
   localparam logic [3:0] CMD_MEM_WR = 4'h7;
   localparam logic [3:0] CMD_CFG_RD = 4'hA;
   localparam logic [3:0] CMD_CFG_WR = 4'hB;
   localparam logic [3:0] CBE_ALL_ON = 4'h0;
   localparam logic [31:0] BAR_MASK = 32'hFFFF_F000;
   localparam logic [31:0] BAR_RESET = 32'h0000_0000;
   localparam logic [31:0] CFG_RD_RESET = 32'h0000_0000;
   localparam logic [1:0] AUX_PRESENT = 2'h1;
   localparam logic [1:0] AUX_ABSENT = 2'h0;
   // Request from the user side for one single-word master cycle
   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] data;
      logic [3:0] cmd;
      logic [3:0] be_n;
   } ppi_mreq_s;
   // One observed target access handed to the user side
   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] data;
      logic [3:0] be_n;
      logic is_cfg;
      logic is_wr;
   } ppi_tacc_s;
   typedef enum logic [2:0] {
      ST_IDLE, ST_REQ, ST_ADDR, ST_DATA, ST_TURN, ST_T_DATA, ST_T_TURN
   } ppi_state_e;
endpackage

// ===== logic/ppi_parity.sv
`timescale 1ns/1ns
// Even parity over one address or data phase
module ppi_parity (
   // Phase content
   input wire logic [31:0] ad,
   input wire logic [3:0] cbe,
   // Result
   output logic par
);
   always_comb begin
      par = ^{ad, cbe};
   end
endmodule

// ===== logic/ppi_core.sv
`timescale 1ns/1ns
// Pin-level bus interface: target, master, parity, error and power pins
// Notes on behaviour
// - Parity is even, one clock after phase
// - Command in address phase, byte enables after
// - Command lines driven only while mastering
// - Master holds frame until its last data phase
// - Initiator ready marks master data readiness
// - Target ready marks target data readiness
// - Stop from target ends master transaction
// - Configuration cycles answered only with select high
// - Device select asserted on own address decode
// - Request low asks bus; floats in reset
// - Data parity errors reported on parity error
// - Address parity errors pull system error
// - Interrupt line low while enabled source pending
// - All bus signals on rising clock edge
// - Power event pulls event line low
// - Clock-run line asserts clock still needed
// - Aux select drives card to aux rail
// - Supply sense inputs are active high
// - Main power gone shields wake logic from reset
// - Aux sense sets reported aux power value
module ppi_core (
   // Clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // Address/data and command lines
   input wire logic [31:0] ad_i,
   output logic [31:0] ad_o,
   output logic ad_oe,
   input wire logic [3:0] cbe_n_i,
   output logic [3:0] cbe_n_o,
   output logic cbe_oe,
   input wire logic par_i,
   output logic par_o,
   output logic par_oe,
   // Handshake lines
   input wire logic frame_n_i,
   output logic frame_n_o,
   output logic frame_oe,
   input wire logic irdy_n_i,
   output logic irdy_n_o,
   output logic irdy_oe,
   input wire logic trdy_n_i,
   output logic trdy_n_o,
   output logic trdy_oe,
   input wire logic stop_n_i,
   output logic stop_n_o,
   output logic stop_oe,
   input wire logic devsel_n_i,
   output logic devsel_n_o,
   output logic devsel_oe,
   input wire logic idsel,
   // Arbitration
   output logic req_n_o,
   output logic req_oe,
   input wire logic gnt_n,
   // Error and interrupt lines
   input wire logic perr_n_i,
   output logic perr_n_o,
   output logic perr_oe,
   output logic serr_oe,
   output logic inta_oe,
   // Power management pins
   output logic pme_oe,
   input wire logic clkrun_n_i,
   output logic clkrun_oe,
   output logic aux_sel,
   input wire logic main_supply_sense,
   input wire logic aux_supply_sense,
   // User side
   input wire ppi_pkg::ppi_mreq_s mreq,
   input wire logic mreq_valid,
   output logic mreq_ready,
   output logic mdone,
   output logic mstopped,
   output ppi_pkg::ppi_tacc_s tacc,
   output logic tacc_valid,
   input wire logic [31:0] trd_data,
   input wire logic [31:0] bar_base,
   input wire logic [3:0] irq_src,
   input wire logic [3:0] irq_en,
   input wire logic codec_wake,
   input wire logic dsp_wake,
   input wire logic pme_en,
   input wire logic pme_clear,
   input wire logic clk_needed,
   output logic par_err_flag,
   output logic aux_pwr_cap
);
   import ppi_pkg::*;

   // Sync stages for the asynchronous supply sense pins
   logic [1:0] msense_reg, msense_next, asense_reg, asense_next;
   // Bus state
   ppi_state_e state_reg, state_next;
   logic [31:0] ad_reg, ad_next;
   logic ad_oe_reg, ad_oe_next;
   logic [3:0] cbe_reg, cbe_next;
   logic cbe_oe_reg, cbe_oe_next;
   logic req_oe_reg;
   logic par_o_reg, par_oe_reg;
   logic frame_reg, frame_next, irdy_reg, irdy_next;
   logic mst_oe_reg, mst_oe_next;
   logic trdy_reg, trdy_next, stop_reg, stop_next, devsel_reg, devsel_next;
   logic tgt_oe_reg, tgt_oe_next;
   logic req_reg, req_next;
   logic mready_reg, mready_next, mdone_reg, mdone_next, mstop_reg, mstop_next;
   ppi_tacc_s tacc_reg, tacc_next;
   logic tvalid_reg, tvalid_next;
   // Receive parity check
   logic [31:0] rx_ad_reg;
   logic [3:0] rx_cbe_reg;
   logic rx_chk_reg, rx_chk_next, rx_addr_reg, rx_addr_next;
   logic perr_reg, perr_next, serr_reg, serr_next, perr_flag_reg, perr_flag_next;
   // Misc pins
   logic inta_reg, inta_next, pme_reg, pme_next, clkrun_reg, clkrun_next;
   logic aux_sel_reg, aux_sel_next, aux_cap_reg, aux_cap_next;
   logic tx_par, rx_par;
   logic addr_hit, cfg_hit;
   logic prev_frame_n;

   ppi_parity u_tx_par (
      .ad(ad_reg),
      .cbe(cbe_n_i), // Bus value, so target reads cover the master's enables
      .par(tx_par)
   );
   ppi_parity u_rx_par (
      .ad(rx_ad_reg),
      .cbe(rx_cbe_reg),
      .par(rx_par)
   );

   // Target decode in the address phase
   always_comb begin
      cfg_hit = idsel && (cbe_n_i == CMD_CFG_RD || cbe_n_i == CMD_CFG_WR);
      addr_hit = ((ad_i & BAR_MASK) == (bar_base & BAR_MASK)) &&
         (cbe_n_i == CMD_MEM_RD || cbe_n_i == CMD_MEM_WR);
   end

   // Bus sequencer, next values
   always_comb begin
      state_next = state_reg;
      ad_next = ad_reg;
      ad_oe_next = 1'b0;
      cbe_next = cbe_reg;
      cbe_oe_next = cbe_oe_reg;
      frame_next = 1'b1;
      irdy_next = 1'b1;
      mst_oe_next = mst_oe_reg;
      trdy_next = 1'b1;
      stop_next = 1'b1;
      devsel_next = 1'b1;
      tgt_oe_next = 1'b0;
      req_next = req_reg;
      mready_next = 1'b0;
      mdone_next = 1'b0;
      mstop_next = 1'b0;
      tacc_next = tacc_reg;
      tvalid_next = 1'b0;
      rx_chk_next = 1'b0;
      rx_addr_next = 1'b0;
      case (state_reg)
         ST_IDLE: begin
            cbe_oe_next = 1'b0;
            mst_oe_next = 1'b0;
            if (frame_n_i == 1'b0 && prev_frame_n && (cfg_hit || addr_hit)) begin
               tacc_next.addr = ad_i;
               tacc_next.is_cfg = cfg_hit;
               tacc_next.is_wr = cbe_n_i[0];
               devsel_next = 1'b0;
               trdy_next = 1'b0;
               stop_next = 1'b0; // single-word target only
               tgt_oe_next = 1'b1;
               ad_oe_next = ~cbe_n_i[0];
               ad_next = trd_data;
               state_next = ST_T_DATA;
            end else if (mreq_valid) begin
               req_next = 1'b0;
               state_next = ST_REQ;
            end
         end
         ST_REQ: begin
            // Idle bus and grant both needed before the address phase
            if (gnt_n == 1'b0 && frame_n_i && irdy_n_i) begin
               req_next = 1'b1;
               mready_next = 1'b1;
               ad_next = mreq.addr;
               ad_oe_next = 1'b1;
               cbe_next = mreq.cmd;
               cbe_oe_next = 1'b1;
               frame_next = 1'b0;
               mst_oe_next = 1'b1;
               state_next = ST_ADDR;
            end
         end
         ST_ADDR: begin
            ad_next = mreq.data;
            ad_oe_next = mreq.cmd[0];
            cbe_next = mreq.be_n;
            frame_next = 1'b1; // last data phase
            irdy_next = 1'b0;
            state_next = ST_DATA;
         end
         ST_DATA: begin
            ad_oe_next = ad_oe_reg;
            irdy_next = 1'b0;
            if (trdy_n_i == 1'b0 || stop_n_i == 1'b0) begin
               ad_oe_next = 1'b0;
               irdy_next = 1'b1;
               mdone_next = 1'b1;
               mstop_next = trdy_n_i;
               tacc_next.data = ad_i;
               state_next = ST_TURN;
            end
         end
         ST_TURN: begin
            // Drive deasserted levels one clock before releasing
            cbe_oe_next = 1'b0;
            mst_oe_next = 1'b0;
            state_next = ST_IDLE;
         end
         ST_T_DATA: begin
            ad_oe_next = ad_oe_reg;
            tgt_oe_next = 1'b1;
            trdy_next = 1'b0;
            stop_next = 1'b0;
            devsel_next = 1'b0;
            if (irdy_n_i == 1'b0) begin
               ad_oe_next = 1'b0;
               trdy_next = 1'b1;
               stop_next = 1'b1;
               devsel_next = 1'b1;
               tacc_next.data = tacc_reg.is_wr ? ad_i : ad_reg;
               tacc_next.be_n = cbe_n_i;
               tvalid_next = 1'b1;
               rx_chk_next = tacc_reg.is_wr;
               state_next = ST_T_TURN;
            end
         end
         ST_T_TURN: begin
            state_next = ST_IDLE;
         end
         default: state_next = ST_IDLE;
      endcase
      if (frame_n_i == 1'b0 && prev_frame_n && state_reg == ST_IDLE) begin
         rx_addr_next = 1'b1;
      end
      if (state_reg == ST_DATA && ~mreq.cmd[0] && trdy_n_i == 1'b0) begin
         rx_chk_next = 1'b1;
      end
   end

   // Parity check one clock after the sampled phase
   always_comb begin
      perr_next = 1'b1;
      serr_next = 1'b0;
      perr_flag_next = perr_flag_reg;
      if (rx_chk_reg && rx_par != par_i) begin
         perr_next = 1'b0;
         perr_flag_next = 1'b1;
      end
      if (rx_addr_reg && rx_par != par_i) begin
         serr_next = 1'b1;
         perr_flag_next = 1'b1;
      end
   end

   // Side pins; pme stays latched until software clears it
   always_comb begin
      msense_next = {msense_reg[0], main_supply_sense};
      asense_next = {asense_reg[0], aux_supply_sense};
      inta_next = |(irq_src & irq_en);
      pme_next = pme_reg;
      if (pme_clear) begin
         pme_next = 1'b0;
      end
      if (pme_en && (codec_wake || dsp_wake)) begin
         pme_next = 1'b1; // set beats clear
      end
      clkrun_next = clk_needed && clkrun_n_i;
      aux_sel_next = pme_en && asense_reg[1];
      aux_cap_next = asense_reg[1] ? AUX_PRESENT[0] : AUX_ABSENT[0];
   end

   // Bus registers follow the bus reset
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= ST_IDLE;
         ad_reg <= CFG_RD_RESET;
         ad_oe_reg <= 1'b0;
         cbe_reg <= CBE_ALL_ON;
         cbe_oe_reg <= 1'b0;
         req_oe_reg <= 1'b0;
         par_o_reg <= 1'b0;
         par_oe_reg <= 1'b0;
         frame_reg <= 1'b1;
         irdy_reg <= 1'b1;
         mst_oe_reg <= 1'b0;
         trdy_reg <= 1'b1;
         stop_reg <= 1'b1;
         devsel_reg <= 1'b1;
         tgt_oe_reg <= 1'b0;
         req_reg <= 1'b1;
         mready_reg <= 1'b0;
         mdone_reg <= 1'b0;
         mstop_reg <= 1'b0;
         tacc_reg <= '0;
         tvalid_reg <= 1'b0;
         rx_ad_reg <= '0;
         rx_cbe_reg <= '0;
         rx_chk_reg <= 1'b0;
         rx_addr_reg <= 1'b0;
         perr_reg <= 1'b1;
         serr_reg <= 1'b0;
         perr_flag_reg <= 1'b0;
         inta_reg <= 1'b0;
         clkrun_reg <= 1'b0;
         prev_frame_n <= 1'b1;
      end else begin
         state_reg <= state_next;
         ad_reg <= ad_next;
         ad_oe_reg <= ad_oe_next;
         cbe_reg <= cbe_next;
         cbe_oe_reg <= cbe_oe_next;
         req_oe_reg <= 1'b1; // floats until reset ends
         par_o_reg <= tx_par;
         par_oe_reg <= ad_oe_reg;
         frame_reg <= frame_next;
         irdy_reg <= irdy_next;
         mst_oe_reg <= mst_oe_next;
         trdy_reg <= trdy_next;
         stop_reg <= stop_next;
         devsel_reg <= devsel_next;
         tgt_oe_reg <= tgt_oe_next;
         req_reg <= req_next;
         mready_reg <= mready_next;
         mdone_reg <= mdone_next;
         mstop_reg <= mstop_next;
         tacc_reg <= tacc_next;
         tvalid_reg <= tvalid_next;
         rx_ad_reg <= ad_i;
         rx_cbe_reg <= cbe_n_i;
         rx_chk_reg <= rx_chk_next;
         rx_addr_reg <= rx_addr_next;
         perr_reg <= perr_next;
         serr_reg <= serr_next;
         perr_flag_reg <= perr_flag_next;
         inta_reg <= inta_next;
         clkrun_reg <= clkrun_next;
         prev_frame_n <= frame_n_i;
      end
   end

   // Wake logic and aux sense sync: bus reset is ignored while main power is absent
   logic wake_rst_n;
   always_comb begin
      wake_rst_n = arst_n || !msense_reg[1];
   end
   always_ff @(posedge core_clk or negedge wake_rst_n) begin
      if (!wake_rst_n) begin
         pme_reg <= 1'b0;
         aux_sel_reg <= 1'b0;
         aux_cap_reg <= 1'b0;
         asense_reg <= 2'h0;
      end else begin
         pme_reg <= pme_next;
         aux_sel_reg <= aux_sel_next;
         aux_cap_reg <= aux_cap_next;
         asense_reg <= asense_next;
      end
   end
   // Sense sync never reset by the bus, so the shield holds through it
   always_ff @(posedge core_clk) begin
      msense_reg <= msense_next;
   end

   always_comb begin
      ad_o = ad_reg;
      ad_oe = ad_oe_reg;
      cbe_n_o = cbe_reg;
      cbe_oe = cbe_oe_reg;
      par_o = par_o_reg;
      par_oe = par_oe_reg;
      frame_n_o = frame_reg;
      frame_oe = mst_oe_reg;
      irdy_n_o = irdy_reg;
      irdy_oe = mst_oe_reg;
      trdy_n_o = trdy_reg;
      trdy_oe = tgt_oe_reg;
      stop_n_o = stop_reg;
      stop_oe = tgt_oe_reg;
      devsel_n_o = devsel_reg;
      devsel_oe = tgt_oe_reg;
      req_n_o = req_reg;
      req_oe = req_oe_reg;
      perr_n_o = perr_reg;
      perr_oe = ~perr_reg;
      serr_oe = serr_reg;
      inta_oe = inta_reg;
      pme_oe = pme_reg;
      clkrun_oe = clkrun_reg;
      aux_sel = aux_sel_reg;
      mreq_ready = mready_reg;
      mdone = mdone_reg;
      mstopped = mstop_reg;
      tacc = tacc_reg;
      tacc_valid = tvalid_reg;
      par_err_flag = perr_flag_reg;
      aux_pwr_cap = aux_cap_reg;
   end

   a_par_follows: assert property (@(posedge core_clk) disable iff (!arst_n)
      ad_oe_reg |=> par_oe_reg && par_o_reg == $past(tx_par))
      else $error("parity not one clock after driven phase");
   a_cbe_master: assert property (@(posedge core_clk) disable iff (!arst_n)
      cbe_oe_reg |-> mst_oe_reg)
      else $error("command lines driven while not master");
   a_frame_len: assert property (@(posedge core_clk) disable iff (!arst_n)
      (state_reg == ST_ADDR) |-> !frame_reg && mst_oe_reg)
      else $error("frame not asserted in address phase");
   a_irdy_data: assert property (@(posedge core_clk) disable iff (!arst_n)
      (state_reg == ST_ADDR) |=> !irdy_reg)
      else $error("initiator ready missing after address");
   a_stop_end: assert property (@(posedge core_clk) disable iff (!arst_n)
      (state_reg == ST_DATA && !stop_n_i) |=> state_reg == ST_TURN ##1 state_reg == ST_IDLE)
      else $error("master did not end on stop");
   a_cfg_idsel: assert property (@(posedge core_clk) disable iff (!arst_n)
      (state_reg == ST_IDLE && !frame_n_i && prev_frame_n && !idsel && !addr_hit) |=> devsel_reg)
      else $error("claimed cycle without select");
   a_grant_first: assert property (@(posedge core_clk) disable iff (!arst_n)
      (state_reg == ST_REQ && gnt_n) |=> state_reg != ST_ADDR)
      else $error("master started without grant");
   a_int_level: assert property (@(posedge core_clk) disable iff (!arst_n)
      |(irq_src & irq_en) [*2] |-> inta_reg)
      else $error("interrupt not held while pending");
   a_perr_report: assert property (@(posedge core_clk) disable iff (!arst_n)
      (rx_chk_reg && rx_par != par_i) |=> !perr_reg && perr_flag_reg)
      else $error("parity error not reported");
   c_master_done: cover property (@(posedge core_clk) disable iff (!arst_n) mdone_reg && !mstop_reg);
   c_master_stop: cover property (@(posedge core_clk) disable iff (!arst_n) mstop_reg);
   c_target_acc: cover property (@(posedge core_clk) disable iff (!arst_n) tvalid_reg && tacc_reg.is_cfg);
   c_pme_set: cover property (@(posedge core_clk) disable iff (!arst_n) pme_reg);
endmodule

// ===== verification/ppi_host_model.sv
// Host bridge, arbiter and far target model for the bus pins
`timescale 1ns/1ns
module ppi_host_model (
   // Clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // Resolved bus lines
   input wire logic [31:0] ad_i,
   input wire logic [3:0] cbe_n_i,
   input wire logic frame_n_i,
   input wire logic irdy_n_i,
   input wire logic trdy_n_i,
   input wire logic stop_n_i,
   input wire logic devsel_n_i,
   input wire logic req_w,
   // Host drive
   output logic [31:0] h_ad,
   output logic h_ad_oe,
   output logic [3:0] h_cbe,
   output logic h_cbe_oe,
   output logic h_par,
   output logic h_par_oe,
   output logic h_frame,
   output logic h_irdy,
   output logic h_m_oe,
   output logic h_trdy,
   output logic h_stop,
   output logic h_devsel,
   output logic h_t_oe,
   output logic gnt_n,
   output logic idsel
);
   // Bit 0 spoils address parity, bit 1 data parity
   logic [1:0] bad_par = 2'h0;
   logic stop_mode = 1'b0;
   int wait_n = 0;
   int gnt_dly = 0;
   int cnt;
   int gcnt;
   logic [1:0] st;
   logic [31:0] m_addr, m_data;
   logic [3:0] m_cmd, m_be;
   initial begin
      {h_ad_oe, h_cbe_oe, h_par_oe, h_m_oe, idsel} = 5'h0;
      {h_frame, h_irdy} = 2'h3;
      h_ad = 32'h0;
      h_cbe = 4'h0;
   end
   always @(posedge core_clk) begin
      h_par <= ^{h_ad, h_cbe} ^ (h_irdy ? bad_par[0] : bad_par[1]);
      h_par_oe <= h_ad_oe;
   end
   // Grant only while the request stands, after gnt_dly clocks
   always @(posedge core_clk or negedge arst_n)
      if (!arst_n) begin
         gcnt <= 0;
         gnt_n <= 1'b1;
      end else if (req_w !== 1'b0) begin
         gcnt <= 0;
         gnt_n <= 1'b1;
      end else if (gcnt >= gnt_dly)
         gnt_n <= 1'b0;
      else
         gcnt <= gcnt + 1;
   // Far target: claims every cycle from the dut after wait_n clocks
   always @(posedge core_clk or negedge arst_n)
      if (!arst_n) begin
         st <= 2'h0;
         h_t_oe <= 1'b0;
         {h_devsel, h_trdy, h_stop} <= 3'h7;
      end else case (st)
         2'h0: if (!frame_n_i && !h_m_oe) begin
            st <= 2'h1;
            m_addr <= ad_i;
            m_cmd <= cbe_n_i;
            cnt <= 0;
         end
         2'h1: begin
            cnt <= cnt + 1;
            h_t_oe <= 1'b1;
            if (cnt >= wait_n) begin
               h_devsel <= 1'b0;
               h_trdy <= stop_mode;
               h_stop <= !stop_mode;
               st <= 2'h2;
            end
         end
         2'h2: if (!irdy_n_i) begin
            m_data <= ad_i;
            m_be <= cbe_n_i;
            {h_devsel, h_trdy, h_stop} <= 3'h7;
            st <= 2'h3;
         end
         default: begin
            h_t_oe <= 1'b0;
            st <= 2'h0;
         end
      endcase
   // Single-word cycle from the host; gives up after six clocks unclaimed
   task automatic tcyc(input logic [3:0] cmd, input logic sel, input logic [31:0] a, d, input logic [3:0] be,
         output logic [31:0] rd, output logic hit);
      int n;
      @(posedge core_clk);
      idsel <= sel;
      h_frame <= 1'b0;
      h_m_oe <= 1'b1;
      h_ad <= a;
      h_ad_oe <= 1'b1;
      h_cbe <= cmd;
      h_cbe_oe <= 1'b1;
      @(posedge core_clk);
      idsel <= 1'b0;
      h_frame <= 1'b1;
      h_irdy <= 1'b0;
      h_cbe <= be;
      h_ad <= d;
      h_ad_oe <= cmd[0];
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (trdy_n_i && stop_n_i && n < 6);
      rd = ad_i;
      hit = !devsel_n_i;
      h_irdy <= 1'b1;
      h_ad_oe <= 1'b0;
      h_cbe_oe <= 1'b0;
      @(posedge core_clk);
      h_m_oe <= 1'b0;
   endtask
endmodule

// ===== verification/tb_top.sv
// Self-checking bench for the bus pin interface
`timescale 1ns/1ns
module tb_top;
   import ppi_pkg::*;
   logic [31:0] ad_o, trd_data, bar_base, h_ad, ad_q;
   logic [3:0] cbe_n_o, h_cbe, cbe_q, irq_src, irq_en;
   logic ad_oe, cbe_oe, par_o, par_oe, frame_n_o, frame_oe, irdy_n_o, irdy_oe, trdy_n_o, trdy_oe;
   logic stop_n_o, stop_oe, devsel_n_o, devsel_oe, req_n_o, req_oe, perr_n_o, perr_oe, serr_oe;
   logic inta_oe, pme_oe, clkrun_oe, aux_sel, mreq_ready, mdone, mstopped, tacc_valid, par_err_flag;
   logic aux_pwr_cap, core_clk, arst_n, mreq_valid, codec_wake, dsp_wake, pme_en, pme_clear, clk_needed;
   logic main_supply_sense, aux_supply_sense, idsel, gnt_n, h_ad_oe, h_cbe_oe, h_par, h_par_oe;
   logic h_frame, h_irdy, h_m_oe, h_trdy, h_stop, h_devsel, h_t_oe, par_q, gnt_q, foe_q, bad_cbe, early;
   ppi_mreq_s mreq;
   ppi_tacc_s tacc, tacc_got;
   int mismatches, tests_run, cyc, n_tacc, n_done, n_stop, n_perr, n_serr;
   // Undriven data lines show the inverse of their last level, never a stale match
   wire logic [31:0] ad_i = ad_oe ? ad_o : h_ad_oe ? h_ad : ~ad_q;
   wire logic [3:0] cbe_n_i = cbe_oe ? cbe_n_o : h_cbe_oe ? h_cbe : ~cbe_q;
   wire logic par_i = par_oe ? par_o : h_par_oe ? h_par : ~par_q;
   // Control lines carry pull-ups
   wire logic frame_n_i = frame_oe ? frame_n_o : h_m_oe ? h_frame : 1'b1;
   wire logic irdy_n_i = irdy_oe ? irdy_n_o : h_m_oe ? h_irdy : 1'b1;
   wire logic trdy_n_i = trdy_oe ? trdy_n_o : h_t_oe ? h_trdy : 1'b1;
   wire logic stop_n_i = stop_oe ? stop_n_o : h_t_oe ? h_stop : 1'b1;
   wire logic devsel_n_i = devsel_oe ? devsel_n_o : h_t_oe ? h_devsel : 1'b1;
   wire logic perr_n_i = perr_oe ? perr_n_o : 1'b1;
   wire logic req_w = req_oe ? req_n_o : 1'b1;
   wire logic clkrun_n_i = !clkrun_oe;
   ppi_core dut (.*);
   ppi_host_model hm (.*);
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      ad_q <= ad_i;
      cbe_q <= cbe_n_i;
      par_q <= par_i;
      gnt_q <= gnt_n;
      foe_q <= frame_oe;
      if (tacc_valid === 1'b1) begin
         n_tacc <= n_tacc + 1;
         tacc_got <= tacc;
      end
      if (mdone === 1'b1) n_done <= n_done + 1;
      if (mstopped === 1'b1) n_stop <= n_stop + 1;
      if (perr_oe === 1'b1 && perr_n_o === 1'b0) n_perr <= n_perr + 1;
      if (serr_oe === 1'b1) n_serr <= n_serr + 1;
      if (h_m_oe === 1'b1 && cbe_oe !== 1'b0) bad_cbe <= 1'b1;
      // Frame may only rise after a grant seen at the edge before
      if (frame_oe === 1'b1 && foe_q === 1'b0 && gnt_q !== 1'b0) early <= 1'b1;
   end
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 3000) begin
         mismatches++;
         stop_test();
      end
   end
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %s exp %h got %h", nm, exp, got);
      end
   endtask
   task automatic stop_test();
      if (mismatches == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic s_cfg();
      logic [31:0] rd;
      logic hit;
      int n0;
      n0 = n_tacc;
      trd_data <= 32'h1234_5678;
      hm.tcyc(CMD_CFG_WR, 1'b1, 32'h0000_0010, 32'hA5A5_0F0F, 4'h0, rd, hit);
      @(posedge core_clk);
      chk("cfg_wr_hit", 1, hit);
      chk("cfg_wr_tacc", n0 + 1, n_tacc);
      chk("tacc_data", 32'hA5A5_0F0F, tacc_got.data);
      chk("tacc_kind", 2'h3, {tacc_got.is_cfg, tacc_got.is_wr});
      hm.tcyc(CMD_CFG_RD, 1'b1, 32'h0000_0010, 32'h0, 4'h0, rd, hit);
      chk("rd_par", ^{32'h1234_5678, 4'h0}, par_i);
      chk("cfg_rd_data", 32'h1234_5678, rd);
      @(posedge core_clk);
      chk("par_idle", 0, par_oe);
      n0 = n_tacc;
      hm.tcyc(CMD_CFG_WR, 1'b0, 32'h0000_0010, 32'h1, 4'h0, rd, hit);
      @(posedge core_clk);
      chk("cfg_nosel_hit", 0, hit);
      chk("cfg_nosel_tacc", n0, n_tacc);
   endtask
   // Both ends of the 4 KB window, the first address past it, and a refused command
   task automatic s_mem();
      logic [3:0] cmds [4] = '{CMD_MEM_WR, CMD_MEM_RD, CMD_MEM_WR, CMD_IO_WR};
      logic [31:0] adrs [4] = '{32'h1000_0FFC, 32'h1000_0000, 32'h1000_1000, 32'h1000_0004};
      logic [31:0] rd;
      logic hit;
      for (int i = 0; i < 4; i++) begin
         hm.tcyc(cmds[i], 1'b0, adrs[i], 32'hC3C3_0000, 4'h5, rd, hit);
         @(posedge core_clk);
         chk("mem_hit", i < 2, hit);
         if (i == 0) chk("tacc_addr", 32'h1000_0FFC, tacc_got.addr);
         if (i == 0) chk("tacc_be", 4'h5, tacc_got.be_n);
      end
   endtask
   task automatic s_master(input logic stp);
      int n;
      int s0;
      int d0;
      s0 = n_stop;
      d0 = n_done;
      hm.stop_mode = stp;
      hm.gnt_dly = 3;
      hm.wait_n = stp ? 0 : 2;
      mreq <= '{32'h2000_0040, 32'h0BAD_F00D, CMD_MEM_WR, 4'h3};
      mreq_valid <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (mreq_ready !== 1'b1 && n < 50);
      mreq_valid <= 1'b0;
      n = 0;
      while (n_done == d0 && n < 50) begin
         @(posedge core_clk);
         n++;
      end
      chk("m_done", d0 + 1, n_done);
      chk("m_addr", 32'h2000_0040, hm.m_addr);
      chk("m_cmd", CMD_MEM_WR, hm.m_cmd);
      chk("m_data", 32'h0BAD_F00D, hm.m_data);
      chk("m_be", 4'h3, hm.m_be);
      chk("m_stopped", s0 + stp, n_stop);
   endtask
   task automatic s_perr();
      logic [31:0] rd;
      logic hit;
      int p0;
      int s0;
      p0 = n_perr;
      s0 = n_serr;
      hm.bad_par = 2'h2;
      hm.tcyc(CMD_MEM_WR, 1'b0, 32'h1000_0100, 32'h0000_00FF, 4'h0, rd, hit);
      repeat (3) @(posedge core_clk);
      chk("perr_pulse", p0 + 1, n_perr);
      chk("perr_flag", 1, par_err_flag);
      chk("serr_quiet", s0, n_serr);
      hm.bad_par = 2'h1;
      hm.tcyc(CMD_MEM_WR, 1'b0, 32'h1000_0100, 32'h0000_00FF, 4'h0, rd, hit);
      hm.bad_par = 2'h0;
      repeat (3) @(posedge core_clk);
      chk("serr", 1, n_serr > s0);
   endtask
   task automatic s_pins();
      logic seen;
      irq_src <= 4'h6;
      irq_en <= 4'h1;
      repeat (3) @(posedge core_clk);
      chk("inta_masked", 0, inta_oe);
      irq_en <= 4'h2;
      aux_supply_sense <= 1'b1;
      pme_en <= 1'b1;
      clk_needed <= 1'b1;
      seen = 1'b0;
      repeat (4) begin
         @(posedge core_clk);
         seen |= clkrun_oe;
      end
      chk("inta_set", 1, inta_oe);
      chk("aux_cap_on", 1, aux_pwr_cap);
      chk("clkrun_on", 1, seen);
      chk("aux_sel_on", 1, aux_sel);
      irq_src <= 4'h0;
      aux_supply_sense <= 1'b0;
      clk_needed <= 1'b0;
      repeat (4) @(posedge core_clk);
      chk("inta_clr", 0, inta_oe);
      chk("aux_cap_off", 0, aux_pwr_cap);
      chk("clkrun_off", 0, clkrun_oe);
      chk("aux_sel_off", 0, aux_sel);
   endtask
   // Wake event must survive a bus reset once main power is gone
   task automatic s_pme();
      pme_en <= 1'b1;
      codec_wake <= 1'b1;
      @(posedge core_clk);
      codec_wake <= 1'b0;
      repeat (3) @(posedge core_clk);
      chk("pme_codec", 1, pme_oe);
      pme_clear <= 1'b1;
      @(posedge core_clk);
      pme_clear <= 1'b0;
      repeat (3) @(posedge core_clk);
      chk("pme_clr", 0, pme_oe);
      dsp_wake <= 1'b1;
      main_supply_sense <= 1'b0;
      @(posedge core_clk);
      dsp_wake <= 1'b0;
      repeat (3) @(posedge core_clk);
      arst_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      chk("pme_kept", 1, pme_oe);
      chk("req_float", 0, req_oe);
      arst_n <= 1'b1;
      main_supply_sense <= 1'b1;
      repeat (3) @(posedge core_clk);
   endtask
   initial begin
      {arst_n, mreq_valid, codec_wake, dsp_wake, pme_en, pme_clear, clk_needed, aux_supply_sense} = 8'h0;
      {main_supply_sense, bad_cbe, early, par_q} = 4'h8;
      mreq = '0;
      trd_data = 32'h0;
      bar_base = 32'h1000_0000;
      irq_src = 4'h0;
      irq_en = 4'h0;
      ad_q = 32'h0;
      cbe_q = 4'h0;
      repeat (2) @(posedge core_clk);
      chk("req_oe_rst", 0, req_oe);
      chk("cbe_oe_rst", 0, cbe_oe);
      arst_n <= 1'b1;
      @(posedge core_clk);
      s_cfg();
      s_mem();
      s_master(1'b0);
      s_master(1'b1);
      s_perr();
      s_pins();
      s_pme();
      chk("cbe_as_target", 0, bad_cbe);
      chk("frame_before_gnt", 0, early);
      stop_test();
   end
endmodule
